// File: rtl/idp_host_port.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RULE_01: disk mode only when mode-select is grounded through power-up.
// RULE_02: optionally leave disk mode when mode-select is seen high.
// RULE_03: optionally redo the mode choice on each card reset pin transition.
// RULE_04: optionally enter disk mode after mode-select stays low long enough.
// RULE_05: command block addresses 1-7 are byte registers on the low lanes.
// RULE_06: control block address 6 is control/alt status, 7 drive address.
// RULE_07: address 0 and multiword DMA move full words, odd byte high.
// RULE_08: Ultra DMA writes need both selects high and DMA acknowledge low.
// RULE_09: Ultra DMA reads drive full words with both selects high.
// RULE_10: host checks all cards support I/O faster than 250 ns first.
// RULE_11: host treats 100 ns cycles, PIO 5-6, DMA 3-4 as advanced.
// RULE_12: no advanced modes with two cards or a long cable.
// RULE_13: no Ultra DMA while a card without it shares the bus.
// RULE_14: host should pick the fastest mode all parties support.
// RULE_15: speed byte holds function code, write-protect bit, speed code.
// RULE_16: extended speed adds one extension byte with continuation bit clear.
// RULE_17: card reachable at primary or secondary legacy disk ranges.
// RULE_18: card reachable at any decoded 16-byte block or memory space.
// RULE_19: configuration index picks memory, contiguous, primary or secondary map.
// RULE_20: all command and status exchange goes through the task file.
// RULE_21: data register is 16 bits and overlaps error/feature address.
// RULE_22: chosen interface mode is latched until a permitted re-evaluation.
module idp_host_port #(
	parameter int LONG_LOW_US = idp_pkg::LONG_LOW_US
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// host bus pins
	input wire logic disk_mode_select_n,
	input wire logic cmd_block_sel_n,
	input wire logic ctrl_block_sel_n,
	input wire logic dma_ack_n,
	input wire logic io_read_strobe_n,
	input wire logic io_write_strobe_n,
	input wire logic reg_sel_n,
	input wire logic mem_write_strobe_n,
	input wire logic card_reset_n,
	input wire logic [10:0] host_addr,
	input wire logic [15:0] data_in,
	output logic [15:0] data_out_q,
	output logic [1:0] data_oe_q,
	output logic io_ready_q,
	// configuration straps
	input wire logic [1:0] cfg_index,
	input wire logic [1:0] speed_sel,
	input wire logic opt_leave_on_high,
	input wire logic opt_rearb_on_reset,
	input wire logic opt_enter_on_low,
	// media side: status, command and data
	input wire logic [7:0] status_in,
	input wire logic [7:0] error_in,
	input wire logic [15:0] rd_word,
	input wire logic rd_word_valid,
	output logic rd_word_take_q,
	output logic [15:0] wr_word,
	output logic wr_word_valid,
	input wire logic wr_word_ready,
	output logic [7:1][7:0] taskfile_q,
	output logic cmd_strobe_q,
	output logic [7:0] device_control_q,
	output logic disk_mode_q,
	output logic [7:0] speed_code_q,
	output logic [7:0] speed_ext_q
);
	localparam int LONG_LOW_CYC = LONG_LOW_US * 1000 / idp_pkg::CLK_PERIOD_NS;

	idp_pkg::idp_pins_s pins_raw;
	idp_pkg::idp_pins_s pins_meta_q;
	idp_pkg::idp_pins_s pins_q;
	idp_pkg::idp_acc_s acc;
	logic rd_eff_n;
	logic wr_eff_n;
	logic rd_prev_q;
	logic wr_prev_q;
	logic rd_fall;
	logic rd_rise;
	logic wr_rise;
	logic word_acc;
	logic [15:0] rd_val;
	logic [1:0] rd_oe;
	logic push_q;
	logic [15:0] push_data_q;
	logic fifo_ready;
	logic [7:0] drv_addr;

	assign pins_raw = '{
		mode_sel_n: disk_mode_select_n,
		cmd_sel_n: cmd_block_sel_n,
		ctl_sel_n: ctrl_block_sel_n,
		dack_n: dma_ack_n,
		rd_n: io_read_strobe_n,
		wr_n: io_write_strobe_n,
		reg_sel_n: reg_sel_n,
		mem_wr_n: mem_write_strobe_n,
		card_reset_n: card_reset_n,
		addr: host_addr,
		data: data_in
	};

	// every pin crosses two flops; the first stage feeds only the second
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			pins_meta_q <= '1;
			pins_q <= '1;
		end else begin
			pins_meta_q <= pins_raw;
			pins_q <= pins_meta_q;
		end
	end

	idp_mode_sel #(
		.LONG_LOW_CYCLES(LONG_LOW_CYC)
	) u_mode (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.mode_sel_n(pins_q.mode_sel_n),
		.card_reset_n(pins_q.card_reset_n),
		.opt_leave_on_high(opt_leave_on_high),
		.opt_rearb_on_reset(opt_rearb_on_reset),
		.opt_enter_on_low(opt_enter_on_low),
		.disk_mode_q(disk_mode_q)
	);

	// normalise any bus address to one of sixteen task file offsets
	function automatic idp_pkg::idp_acc_s decode(input logic disk, input logic [1:0] cfg,
			input idp_pkg::idp_pins_s p);
		idp_pkg::idp_acc_s r;
		logic [5:0] blk;
		r = '0;
		blk = p.addr[9:4];
		if (disk) begin
			if (!p.dack_n) begin
				r.hit = p.cmd_sel_n & p.ctl_sel_n; // RULE_07 RULE_08 RULE_09
				r.ofs = idp_pkg::OFS_DATA;
			end else if (!p.cmd_sel_n && p.ctl_sel_n) begin
				r.hit = 1'b1; // RULE_05
				r.ofs = {1'b0, p.addr[2:0]};
			end else if (p.cmd_sel_n && !p.ctl_sel_n && p.addr[2:1] == 2'b11) begin
				r.hit = 1'b1; // RULE_06
				r.ofs = {1'b1, p.addr[2:0]};
			end
		end else if (!p.cmd_sel_n) begin
			unique case (cfg)
				idp_pkg::CFG_MEMORY: begin
					r.hit = p.reg_sel_n; // RULE_18 RULE_19
					r.ofs = p.addr[10] ? {3'b100, p.addr[0]} : p.addr[3:0];
				end
				idp_pkg::CFG_CONTIG: begin
					r.hit = ~p.reg_sel_n; // RULE_18 RULE_19
					r.ofs = p.addr[3:0];
				end
				idp_pkg::CFG_PRIMARY, idp_pkg::CFG_SECONDARY: begin
					// RULE_17 RULE_19
					if (blk == ((cfg == idp_pkg::CFG_PRIMARY) ? idp_pkg::PRI_CMD_BLK
							: idp_pkg::SEC_CMD_BLK) && !p.addr[3]) begin
						r.hit = ~p.reg_sel_n;
						r.ofs = {1'b0, p.addr[2:0]};
					end else if (blk == ((cfg == idp_pkg::CFG_PRIMARY) ? idp_pkg::PRI_CTL_BLK
							: idp_pkg::SEC_CTL_BLK) && p.addr[3:1] == idp_pkg::CTL_BLK_LOW) begin
						r.hit = ~p.reg_sel_n;
						r.ofs = {1'b1, p.addr[2:0]};
					end
				end
			endcase
		end
		return r;
	endfunction

	// memory-mapped accesses use the mode pin as their read strobe
	assign rd_eff_n = (!disk_mode_q && cfg_index == idp_pkg::CFG_MEMORY) ? pins_q.mode_sel_n
			: pins_q.rd_n;
	assign wr_eff_n = (!disk_mode_q && cfg_index == idp_pkg::CFG_MEMORY) ? pins_q.mem_wr_n
			: pins_q.wr_n;
	assign rd_fall = rd_prev_q & ~rd_eff_n;
	assign rd_rise = ~rd_prev_q & rd_eff_n;
	assign wr_rise = ~wr_prev_q & wr_eff_n;
	assign acc = decode(disk_mode_q, cfg_index, pins_q);
	assign word_acc = (acc.ofs == idp_pkg::OFS_DATA) || (acc.ofs == idp_pkg::OFS_DUP_EVEN)
			|| (acc.ofs == idp_pkg::OFS_DUP_ODD);

	// drive address byte reflects the selected drive and head; head bits active low, the selected drive's bit high
	assign drv_addr = {1'b1, 1'b1, ~taskfile_q[6][3:0],
			taskfile_q[6][idp_pkg::DRV_SEL_BIT], ~taskfile_q[6][idp_pkg::DRV_SEL_BIT]};

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			rd_prev_q <= 1'b1;
			wr_prev_q <= 1'b1;
		end else begin
			rd_prev_q <= rd_eff_n;
			wr_prev_q <= wr_eff_n;
		end
	end

	// read mux: byte registers leave the upper lanes undriven
	always_comb begin
		rd_val = '0;
		rd_oe = 2'b01; // RULE_05 RULE_06
		unique case (acc.ofs)
			idp_pkg::OFS_DATA, idp_pkg::OFS_DUP_EVEN, idp_pkg::OFS_DUP_ODD: begin
				rd_val = rd_word; // RULE_07 RULE_09 RULE_21
				rd_oe = 2'b11;
			end
			idp_pkg::OFS_ERR_FEAT, idp_pkg::OFS_DUP_ERR: rd_val = {8'h00, error_in};
			idp_pkg::OFS_STAT_CMD, idp_pkg::OFS_ALT_CTL: rd_val = {8'h00, status_in};
			idp_pkg::OFS_DRV_ADDR: rd_val = {8'h00, drv_addr}; // RULE_06
			default: rd_val = {8'h00, taskfile_q[acc.ofs[2:0]]}; // RULE_20
		endcase
	end

	// drive the lanes from the strobe's falling edge until it rises
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			data_out_q <= '0;
			data_oe_q <= '0;
			rd_word_take_q <= 1'b0;
		end else begin
			rd_word_take_q <= 1'b0;
			if (rd_fall && acc.hit) begin
				data_out_q <= rd_val;
				data_oe_q <= rd_oe;
				rd_word_take_q <= word_acc & rd_word_valid;
			end else if (rd_rise || rd_eff_n) begin
				data_oe_q <= '0;
			end
		end
	end

	// register writes are taken on the write strobe's rising edge
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			taskfile_q <= {7{idp_pkg::TF_RESET_VAL}};
			device_control_q <= idp_pkg::CTL_RESET_VAL;
			cmd_strobe_q <= 1'b0;
		end else begin
			cmd_strobe_q <= 1'b0;
			if (wr_rise && acc.hit) begin
				if (acc.ofs == idp_pkg::OFS_ALT_CTL) begin
					device_control_q <= pins_q.data[7:0]; // RULE_06
				end else if (acc.ofs == idp_pkg::OFS_DUP_ERR) begin
					taskfile_q[1] <= pins_q.data[7:0];
				end else if (!acc.ofs[3] && acc.ofs != idp_pkg::OFS_DATA) begin
					taskfile_q[acc.ofs[2:0]] <= pins_q.data[7:0]; // RULE_05 RULE_20
					cmd_strobe_q <= (acc.ofs == idp_pkg::OFS_STAT_CMD);
				end
			end
		end
	end

	// data writes go into the buffer as whole words
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			push_q <= 1'b0;
			push_data_q <= '0;
		end else begin
			push_q <= wr_rise & acc.hit & word_acc; // RULE_07 RULE_08 RULE_21
			push_data_q <= pins_q.data;
		end
	end

	// ready to the host drops when the buffer fills or read data is missing
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			io_ready_q <= 1'b0;
		end else begin
			io_ready_q <= fifo_ready & rd_word_valid;
		end
	end

	idp_fifo #(
		.WIDTH(idp_pkg::WORD_W),
		.DEPTH(idp_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.in_data(push_data_q),
		.in_valid(push_q),
		.in_ready(fifo_ready),
		.out_data(wr_word),
		.out_valid(wr_word_valid),
		.out_ready(wr_word_ready)
	);

	// speed descriptor bytes for the selected timing
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			speed_code_q <= idp_pkg::SPD_250NS;
			speed_ext_q <= idp_pkg::SPD_NO_EXT;
		end else begin
			unique case (idp_pkg::idp_speed_e'(speed_sel))
				idp_pkg::IDP_SPD_250: begin
					speed_code_q <= idp_pkg::SPD_250NS; // RULE_15
					speed_ext_q <= idp_pkg::SPD_NO_EXT;
				end
				idp_pkg::IDP_SPD_100: begin
					speed_code_q <= idp_pkg::SPD_100NS; // RULE_15
					speed_ext_q <= idp_pkg::SPD_NO_EXT;
				end
				idp_pkg::IDP_SPD_120: begin
					speed_code_q <= idp_pkg::SPD_EXTENDED;
					speed_ext_q <= idp_pkg::SPD_EXT_120NS; // RULE_16
				end
				idp_pkg::IDP_SPD_80: begin
					speed_code_q <= idp_pkg::SPD_EXTENDED;
					speed_ext_q <= idp_pkg::SPD_EXT_80NS; // RULE_16
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// File: rtl/idp_pkg.sv
package idp_pkg;

	// task file offsets inside the normalised 16-entry register window
	localparam logic [3:0] OFS_DATA = 4'h0;
	localparam logic [3:0] OFS_ERR_FEAT = 4'h1;
	localparam logic [3:0] OFS_STAT_CMD = 4'h7;
	localparam logic [3:0] OFS_DUP_EVEN = 4'h8;
	localparam logic [3:0] OFS_DUP_ODD = 4'h9;
	localparam logic [3:0] OFS_DUP_ERR = 4'hD;
	localparam logic [3:0] OFS_ALT_CTL = 4'hE;
	localparam logic [3:0] OFS_DRV_ADDR = 4'hF;

	// control block addresses seen with the control-block select low
	localparam logic [2:0] CTL_ADDR_ALT = 3'h6;
	localparam logic [2:0] CTL_ADDR_DRV = 3'h7;

	// legacy disk ranges, address bits 9..4
	localparam logic [5:0] PRI_CMD_BLK = 6'h1F;
	localparam logic [5:0] PRI_CTL_BLK = 6'h3F;
	localparam logic [5:0] SEC_CMD_BLK = 6'h17;
	localparam logic [5:0] SEC_CTL_BLK = 6'h37;
	localparam logic [2:0] CTL_BLK_LOW = 3'h6;

	// mapping configuration indices
	localparam logic [1:0] CFG_MEMORY = 2'h0;
	localparam logic [1:0] CFG_CONTIG = 2'h1;
	localparam logic [1:0] CFG_PRIMARY = 2'h2;
	localparam logic [1:0] CFG_SECONDARY = 2'h3;

	// speed descriptor bytes
	localparam logic [7:0] SPD_250NS = 8'hD9;
	localparam logic [7:0] SPD_100NS = 8'hDC;
	localparam logic [7:0] SPD_EXTENDED = 8'hDF;
	localparam logic [7:0] SPD_EXT_120NS = 8'h12;
	localparam logic [7:0] SPD_EXT_80NS = 8'h79;
	localparam logic [7:0] SPD_NO_EXT = 8'h00;
	localparam int SPD_WP_BIT = 3;
	localparam int SPD_MORE_BIT = 7;

	// drive/head register fields
	localparam int DRV_SEL_BIT = 4;
	localparam logic [7:0] CTL_RESET_VAL = 8'h00;
	localparam logic [7:0] TF_RESET_VAL = 8'h00;

	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int SETTLE_CYCLES = 3;
	localparam int LONG_LOW_US = 1000;
	localparam int FIFO_DEPTH = 32;
	localparam int WORD_W = 16;

	// speed descriptor selection
	typedef enum logic [1:0] {
		IDP_SPD_250,
		IDP_SPD_100,
		IDP_SPD_120,
		IDP_SPD_80
	} idp_speed_e;

	// host bus pins as one bundle, synchronised together
	typedef struct packed {
		logic mode_sel_n;
		logic cmd_sel_n;
		logic ctl_sel_n;
		logic dack_n;
		logic rd_n;
		logic wr_n;
		logic reg_sel_n;
		logic mem_wr_n;
		logic card_reset_n;
		logic [10:0] addr;
		logic [15:0] data;
	} idp_pins_s;

	// result of address decoding
	typedef struct packed {
		logic hit;
		logic [3:0] ofs;
	} idp_acc_s;

endpackage

// File: rtl/idp_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module idp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// filling side
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// draining side
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	// honest flags straight from the occupancy count
	assign in_ready = (cnt_q != FULL_CNT);
	assign out_valid = (cnt_q != '0);
	assign out_data = mem[rp_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// storage has no reset, only the pointers and the count do
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wp_q] <= in_data;
		end
	end

	// pointers wrap naturally for a power-of-two depth
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= rp_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// File: rtl/idp_mode_sel.sv
`timescale 1ns/100ps
`default_nettype none
module idp_mode_sel #(
	parameter int LONG_LOW_CYCLES = 50000
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// synchronised pin levels
	input wire logic mode_sel_n,
	input wire logic card_reset_n,
	// optional behaviour enables
	input wire logic opt_leave_on_high,
	input wire logic opt_rearb_on_reset,
	input wire logic opt_enter_on_low,
	// chosen mode
	output logic disk_mode_q
);
	localparam int CW = $clog2(LONG_LOW_CYCLES + 1);
	localparam logic [CW-1:0] LOW_LIMIT = CW'(LONG_LOW_CYCLES);
	localparam logic [1:0] SETTLE = 2'(idp_pkg::SETTLE_CYCLES);

	logic [1:0] settle_q;
	logic reset_prev_q;
	logic [CW-1:0] low_cnt_q;
	logic reset_edge;

	assign reset_edge = reset_prev_q ^ card_reset_n;

	// wait for the synchroniser to fill before the power-on sample
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			settle_q <= '0;
		end else if (settle_q != SETTLE) begin
			settle_q <= settle_q + 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			reset_prev_q <= 1'b1;
		end else begin
			reset_prev_q <= card_reset_n;
		end
	end

	// counts a continuous low level, restarts on any high
	always_ff @(posedge clk_sys) begin
		if (!nrst || mode_sel_n) begin
			low_cnt_q <= '0;
		end else if (low_cnt_q != LOW_LIMIT) begin
			low_cnt_q <= low_cnt_q + 1'b1;
		end
	end

	// mode is latched once and only moved by an enabled event
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			disk_mode_q <= 1'b0;
		end else if (settle_q == SETTLE - 2'd1) begin
			disk_mode_q <= ~mode_sel_n; // RULE_01 RULE_22
		end else if (settle_q == SETTLE) begin
			if (opt_rearb_on_reset && reset_edge) begin
				disk_mode_q <= ~mode_sel_n; // RULE_03
			end else if (opt_leave_on_high && mode_sel_n) begin
				disk_mode_q <= 1'b0; // RULE_02
			end else if (opt_enter_on_low && low_cnt_q == LOW_LIMIT) begin
				disk_mode_q <= 1'b1; // RULE_04
			end
		end
	end
endmodule
`default_nettype wire

// File: test/idp_host_port_props.sv
`timescale 1ns/100ps
`default_nettype none
module idp_host_port_props #(
	parameter int LONG_LOW_US = 1000
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// host pins
	input wire logic disk_mode_select_n,
	input wire logic cmd_block_sel_n,
	input wire logic ctrl_block_sel_n,
	input wire logic dma_ack_n,
	input wire logic io_read_strobe_n,
	input wire logic io_write_strobe_n,
	input wire logic [10:0] host_addr,
	input wire logic [15:0] data_in,
	input wire logic [15:0] data_out_q,
	input wire logic [1:0] data_oe_q,
	// straps and media side
	input wire logic [1:0] speed_sel,
	input wire logic opt_leave_on_high,
	input wire logic opt_enter_on_low,
	input wire logic [7:0] status_in,
	input wire logic wr_word_valid,
	input wire logic [7:1][7:0] taskfile_q,
	input wire logic cmd_strobe_q,
	input wire logic disk_mode_q,
	input wire logic [7:0] speed_code_q,
	input wire logic [7:0] speed_ext_q
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// margin for the sync and compare stages
	localparam int LOW_LIM = LONG_LOW_US * 50 + 8;
	logic [7:0] code_exp;
	logic [7:0] ext_exp;
	logic tf_sel;
	logic ct_sel;
	logic wd_sel;
	logic [31:0] low_cnt_q;
	// expected speed bytes and decoded access kinds
	assign code_exp = speed_sel[1] ? 8'hDF : (speed_sel[0] ? 8'hDC : 8'hD9);
	assign ext_exp = !speed_sel[1] ? 8'h00 : (speed_sel[0] ? 8'h79 : 8'h12);
	assign tf_sel = disk_mode_q && ctrl_block_sel_n && !cmd_block_sel_n && dma_ack_n;
	assign ct_sel = disk_mode_q && !ctrl_block_sel_n && cmd_block_sel_n && dma_ack_n;
	assign wd_sel = (tf_sel && host_addr[2:0] == 3'h0)
		|| (disk_mode_q && ctrl_block_sel_n && cmd_block_sel_n && !dma_ack_n);
	// cycles of mode pin low with long-low entry on
	always_ff @(posedge clk_sys) begin
		if (!nrst || disk_mode_select_n || !opt_enter_on_low) begin
			low_cnt_q <= 32'h0000_0000;
		end else if (low_cnt_q != 32'hFFFF_FFFF) begin
			low_cnt_q <= low_cnt_q + 32'h0000_0001;
		end
	end
	a_status_read: assert property ($rose(data_oe_q[0]) && tf_sel && host_addr[2:0] == 3'h7
		|-> data_out_q[7:0] == status_in && data_oe_q == 2'b01) else $error("status read wrong");
	a_alt_status: assert property ($rose(data_oe_q[0]) && ct_sel && host_addr[2:0] == 3'h6
		|-> data_out_q[7:0] == status_in && data_oe_q == 2'b01) else $error("alt status wrong");
	a_drive_addr: assert property ($rose(data_oe_q[0]) && ct_sel && host_addr[2:0] == 3'h7
		|-> data_out_q[7:0] == {2'b11, ~taskfile_q[6][3:0], taskfile_q[6][4], ~taskfile_q[6][4]})
		else $error("drive address wrong");
	a_upper_quiet: assert property (disk_mode_q && data_oe_q[1] |-> wd_sel)
		else $error("upper lanes driven on byte access");
	a_oe_release: assert property ((disk_mode_q && io_read_strobe_n)[*5] |-> data_oe_q == 2'b00)
		else $error("lanes still driven after read");
	a_both_refused: assert property ((!cmd_block_sel_n && !ctrl_block_sel_n)[*4]
		|-> data_oe_q == 2'b00) else $error("invalid select drove bus");
	a_cmd_written: assert property ($rose(io_write_strobe_n) && tf_sel && host_addr[2:0] == 3'h7
		|-> ##[2:5] (cmd_strobe_q && taskfile_q[7] == data_in[7:0])) else $error("command lost");
	a_word_push: assert property ($rose(io_write_strobe_n) && wd_sel |-> ##[1:5] wr_word_valid)
		else $error("data word not pushed");
	a_speed_code: assert property ($stable(speed_sel)[*4]
		|-> speed_code_q == code_exp && speed_ext_q == ext_exp) else $error("speed bytes wrong");
	a_mode_power: assert property ($rose(nrst) && !disk_mode_select_n |-> ##[1:5] disk_mode_q)
		else $error("disk mode not taken at power-on");
	a_mode_card: assert property ($rose(nrst) && disk_mode_select_n && !opt_enter_on_low
		|-> !disk_mode_q [*6]) else $error("disk mode with pin high");
	a_leave_high: assert property ((opt_leave_on_high && disk_mode_select_n)[*3]
		|-> ##[0:4] !disk_mode_q) else $error("disk mode kept with pin high");
	a_enter_low: assert property (low_cnt_q >= LOW_LIM |-> disk_mode_q)
		else $error("long low did not enter disk mode");
	c_command: cover property ($rose(cmd_strobe_q));
	c_word_read: cover property (data_oe_q == 2'b11);
	c_leave: cover property ($fell(disk_mode_q));
endmodule
bind idp_host_port idp_host_port_props #(.LONG_LOW_US(LONG_LOW_US)) u_idp_host_port_props (
	.clk_sys(clk_sys), .nrst(nrst), .disk_mode_select_n(disk_mode_select_n),
	.cmd_block_sel_n(cmd_block_sel_n), .ctrl_block_sel_n(ctrl_block_sel_n), .dma_ack_n(dma_ack_n),
	.io_read_strobe_n(io_read_strobe_n), .io_write_strobe_n(io_write_strobe_n),
	.host_addr(host_addr), .data_in(data_in), .data_out_q(data_out_q), .data_oe_q(data_oe_q),
	.speed_sel(speed_sel), .opt_leave_on_high(opt_leave_on_high), .opt_enter_on_low(opt_enter_on_low),
	.status_in(status_in), .wr_word_valid(wr_word_valid), .taskfile_q(taskfile_q),
	.cmd_strobe_q(cmd_strobe_q), .disk_mode_q(disk_mode_q), .speed_code_q(speed_code_q),
	.speed_ext_q(speed_ext_q));
`default_nettype wire

// File: test/idp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module idp_host_model (
	// clock
	input wire logic clk_sys,
	// host bus pins
	output logic cmd_block_sel_n,
	output logic ctrl_block_sel_n,
	output logic dma_ack_n,
	output logic io_read_strobe_n,
	output logic io_write_strobe_n,
	output logic [10:0] host_addr,
	output logic [15:0] data_in,
	// answer from the card
	input wire logic [15:0] data_out_q,
	input wire logic [1:0] data_oe_q
);
	// bus idles deselected with strobes high
	initial begin
		{ctrl_block_sel_n, cmd_block_sel_n, dma_ack_n} = 3'b111;
		{io_read_strobe_n, io_write_strobe_n} = 2'b11;
		host_addr = 11'h000;
		data_in = 16'h0000;
	end
	// one access; s is {ctrl select, command select, dma acknowledge}
	task automatic acc(input logic [2:0] s, input logic [10:0] a, input logic w,
		input logic [15:0] wd, output logic [15:0] rd, output logic [1:0] oe);
		@(posedge clk_sys);
		#1 {ctrl_block_sel_n, cmd_block_sel_n, dma_ack_n} = s;
		host_addr = a;
		if (w) data_in = wd;
		// slow legacy timing, no speed limits apply
		repeat (3) @(posedge clk_sys);
		#1 {io_write_strobe_n, io_read_strobe_n} = {!w, w};
		repeat (5) @(posedge clk_sys);
		rd = data_out_q;
		oe = data_oe_q;
		#1 {io_write_strobe_n, io_read_strobe_n} = 2'b11;
		repeat (5) @(posedge clk_sys);
		// released data is inverted so stale values fail
		#1 {ctrl_block_sel_n, cmd_block_sel_n, dma_ack_n} = 3'b111;
		data_in = ~data_in;
	endtask
endmodule
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic disk_mode_select_n = 1'b0;
	logic card_reset_n = 1'b1;
	logic [1:0] speed_sel = 2'h0;
	logic opt_leave_on_high = 1'b0;
	logic opt_rearb_on_reset = 1'b0;
	logic opt_enter_on_low = 1'b0;
	logic [7:0] status_in = 8'h50;
	logic [15:0] rd_word = 16'hA5C3;
	logic wr_word_ready = 1'b0, rd_word_valid = 1'b1;
	wire logic cmd_block_sel_n, ctrl_block_sel_n, dma_ack_n, io_read_strobe_n, io_write_strobe_n;
	wire logic [10:0] host_addr;
	wire logic [15:0] data_in;
	logic [15:0] data_out_q, wr_word;
	logic [1:0] data_oe_q;
	logic io_ready_q, rd_word_take_q, wr_word_valid, cmd_strobe_q, disk_mode_q;
	logic [7:1][7:0] taskfile_q;
	logic [7:0] device_control_q, speed_code_q, speed_ext_q;
	logic [7:0] spd_tab [4] = '{8'hD9, 8'hDC, 8'hDF, 8'hDF};
	logic [7:0] ext_tab [4] = '{8'h00, 8'h00, 8'h12, 8'h79};
	logic [7:0] tfv;
	int fail_count = 0, checked = 0, n = 0, takes = 0;
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (rd_word_take_q === 1'b1) takes++;
	// long-low entry shortened to 50 cycles
	idp_host_port #(.LONG_LOW_US(1)) u_idp_host_port (.clk_sys(clk_sys), .nrst(nrst),
		.disk_mode_select_n(disk_mode_select_n), .cmd_block_sel_n(cmd_block_sel_n),
		.ctrl_block_sel_n(ctrl_block_sel_n), .dma_ack_n(dma_ack_n),
		.io_read_strobe_n(io_read_strobe_n), .io_write_strobe_n(io_write_strobe_n),
		.reg_sel_n(1'b0), .mem_write_strobe_n(1'b1), .card_reset_n(card_reset_n),
		.host_addr(host_addr), .data_in(data_in), .data_out_q(data_out_q), .data_oe_q(data_oe_q),
		.io_ready_q(io_ready_q), .cfg_index(2'h2), .speed_sel(speed_sel),
		.opt_leave_on_high(opt_leave_on_high), .opt_rearb_on_reset(opt_rearb_on_reset),
		.opt_enter_on_low(opt_enter_on_low), .status_in(status_in), .error_in(8'h5A),
		.rd_word(rd_word), .rd_word_valid(rd_word_valid), .rd_word_take_q(rd_word_take_q),
		.wr_word(wr_word), .wr_word_valid(wr_word_valid), .wr_word_ready(wr_word_ready),
		.taskfile_q(taskfile_q), .cmd_strobe_q(cmd_strobe_q), .device_control_q(device_control_q),
		.disk_mode_q(disk_mode_q), .speed_code_q(speed_code_q), .speed_ext_q(speed_ext_q));
	idp_host_model u_idp_host_model (.clk_sys(clk_sys), .cmd_block_sel_n(cmd_block_sel_n),
		.ctrl_block_sel_n(ctrl_block_sel_n), .dma_ack_n(dma_ack_n),
		.io_read_strobe_n(io_read_strobe_n), .io_write_strobe_n(io_write_strobe_n),
		.host_addr(host_addr), .data_in(data_in), .data_out_q(data_out_q), .data_oe_q(data_oe_q));
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [2:0] s, input logic [10:0] a, input logic [15:0] d);
		logic [15:0] r;
		logic [1:0] o;
		u_idp_host_model.acc(s, a, 1'b1, d, r, o);
	endtask
	// upper byte checked only on word reads
	task automatic rd(input logic [2:0] s, input logic [10:0] a, input logic [15:0] e,
		input logic [1:0] eo);
		logic [15:0] r;
		logic [1:0] o;
		u_idp_host_model.acc(s, a, 1'b0, 16'h0000, r, o);
		chk("data_oe_q", 16'(eo), 16'(o));
		if (eo != 2'b00) chk("data_out_q", e & {{8{eo[1]}}, 8'hFF}, r & {{8{eo[1]}}, 8'hFF});
	endtask
	// bounded wait; running out ends the run
	task automatic wait_mode(input logic v);
		int i;
		for (i = 0; i < 200 && disk_mode_q !== v; i++) cyc(1);
		chk("disk_mode_q", 16'(v), 16'(disk_mode_q));
		if (i == 200) summarize();
	endtask
	initial begin
		repeat (4) @(posedge clk_sys);
		#1 nrst = 1'b1;
		cyc(6);
		chk("disk_mode_q", 16'h0001, 16'(disk_mode_q));
		for (int k = 0; k < 4; k++) begin
			speed_sel = k[1:0];
			cyc(5);
			chk("speed_code_q", {8'h00, spd_tab[k]}, {8'h00, speed_code_q});
			chk("speed_ext_q", {8'h00, ext_tab[k]}, {8'h00, speed_ext_q});
		end
		$display("test speed done");
		for (int k = 1; k < 8; k++) begin
			tfv = (k == 6) ? 8'hB2 : 8'h30 + 8'(k);
			wr(3'b101, 11'(k), {8'hC3, tfv});
			chk("taskfile_q", {8'h00, tfv}, {8'h00, taskfile_q[k]});
			rd(3'b101, 11'(k), {8'h00, k == 1 ? 8'h5A : k == 7 ? status_in : tfv}, 2'b01);
		end
		$display("test taskfile done");
		wr(3'b011, 11'h006, 16'h0006);
		chk("device_control_q", 16'h0006, {8'h00, device_control_q});
		status_in = 8'h51;
		rd(3'b011, 11'h006, 16'h0051, 2'b01);
		rd(3'b011, 11'h007, 16'h00F6, 2'b01);
		wr(3'b001, 11'h006, 16'h0004);
		chk("device_control_q", 16'h0006, {8'h00, device_control_q});
		rd(3'b001, 11'h007, 16'h0000, 2'b00);
		$display("test control done");
		rd(3'b101, 11'h000, 16'hA5C3, 2'b11);
		rd_word = 16'h3C5A;
		rd(3'b110, 11'h003, 16'h3C5A, 2'b11);
		chk("rd_word_take_q", 16'd2, 16'(takes));
		for (int k = 0; k < 33; k++) wr(k[0] ? 3'b110 : 3'b101, 11'h000, 16'h0101 * 16'(k));
		chk("io_ready_q", 16'h0000, 16'(io_ready_q));
		wr_word_ready = 1'b1;
		for (int k = 0; k < 64; k++) begin
			@(negedge clk_sys);
			if (wr_word_valid === 1'b1) begin
				chk("wr_word", 16'h0101 * 16'(n), wr_word);
				n++;
			end
		end
		chk("word_count", 16'd32, 16'(n));
		chk("io_ready_q", 16'h0001, 16'(io_ready_q));
		rd_word_valid = 1'b0;
		cyc(2);
		chk("io_ready_q", 16'h0000, 16'(io_ready_q));
		$display("test words done");
		opt_leave_on_high = 1'b1;
		disk_mode_select_n = 1'b1;
		wait_mode(1'b0);
		opt_leave_on_high = 1'b0;
		opt_enter_on_low = 1'b1;
		disk_mode_select_n = 1'b0;
		cyc(20);
		chk("disk_mode_q", 16'h0000, 16'(disk_mode_q));
		wait_mode(1'b1);
		cyc(10);
		opt_enter_on_low = 1'b0;
		opt_rearb_on_reset = 1'b1;
		disk_mode_select_n = 1'b1;
		cyc(10);
		chk("disk_mode_q", 16'h0001, 16'(disk_mode_q));
		card_reset_n = 1'b0;
		wait_mode(1'b0);
		disk_mode_select_n = 1'b0;
		card_reset_n = 1'b1;
		wait_mode(1'b1);
		opt_rearb_on_reset = 1'b0;
		disk_mode_select_n = 1'b1;
		nrst = 1'b0;
		cyc(4);
		nrst = 1'b1;
		cyc(8);
		chk("disk_mode_q", 16'h0000, 16'(disk_mode_q));
		disk_mode_select_n = 1'b0;
		cyc(20);
		chk("disk_mode_q", 16'h0000, 16'(disk_mode_q));
		$display("test mode done");
		summarize();
	end
endmodule
`default_nettype wire
